// >>> hw/aslc_top.sv
// slot sequencer: input routing, second channel gating, led drive
// assumes per-slot configuration presented as plain ports
`include "aslc_consts.svh"
module aslc_top #(
    parameter int NUM_SLOTS = `ASLC_NUM_SLOTS,
    parameter int PULSE_CYC = 64,
    parameter int GAIN_W    = 4
) (
    input  wire logic                          MCLK,
    input  wire logic                          RESET,
    input  wire logic                          START_PERIOD,
    input  wire logic [NUM_SLOTS-1:0]          SLOT_ENABLE,
    input  wire logic                          FIRST_PAIR_DIFFERENTIAL,
    input  wire logic                          SECOND_PAIR_DIFFERENTIAL,
    input  wire aslc_pkg::aslc_pin_state_t     FIRST_PAIR_IDLE_STATE,
    input  wire aslc_pkg::aslc_pin_state_t     SECOND_PAIR_IDLE_STATE,
    input  wire logic [NUM_SLOTS-1:0]          SLOT_NO_CH2_MODE,
    input  wire aslc_pkg::aslc_slot_cfg_t      SLOT_CFG [NUM_SLOTS],
    input  wire logic [GAIN_W-1:0]             CH1_GAIN,
    input  wire logic [GAIN_W-1:0]             CH2_GAIN,
    input  wire logic                          ADC_DONE,
    output aslc_pkg::aslc_input_ctl_t          IN_CTL [4],
    output logic [GAIN_W-1:0]                  CH1_GAIN_APPLIED,
    output logic [GAIN_W-1:0]                  CH2_GAIN_APPLIED,
    output logic                               CH2_POWER_ON,
    output logic                               ADC_START,
    output logic                               ADC_SEL_CH2,
    output logic                               DATA_WRITE,
    output logic                               DATA_IS_CH2,
    output logic [3:0]                         SLOT_ID,
    output logic                               BUSY,
    output logic [4*`ASLC_CODE_W-1:0]          DRIVER_CODES
);
    typedef enum logic [4:0] {
        ASLC_IDLE  = 5'h01,
        ASLC_PRE   = 5'h02,
        ASLC_PULSE = 5'h04,
        ASLC_CONV  = 5'h08,
        ASLC_NEXT  = 5'h10
    } aslc_state_t;

    localparam int CW = `ASLC_CODE_W;
    aslc_state_t state_reg, state_next;
    logic [3:0]  slot_reg;
    logic [15:0] cnt_reg;
    logic        conv2_reg;
    logic [4*CW-1:0] codes_reg;
    logic        ch2_slot_reg;

    aslc_pkg::aslc_slot_cfg_t cur;
    assign cur = SLOT_CFG[slot_reg];

    // zero pre width falls back to the default period
    wire [15:0] pre_len = (cur.pre_cycles == 16'h0000) ?
                          16'(`ASLC_PRE_CYC_DEF) : cur.pre_cycles;
    wire ch2_allowed = cur.slot_second_channel_on && !SLOT_NO_CH2_MODE[slot_reg];
    wire [3:0] side_on;
    genvar d;
    generate
        for (d = 0; d < 4; d++)
        begin : g_side
            // zero code means driver off
            assign side_on[d] = cur.side_select[d] &&
                                (cur.current_codes[d*CW +: CW] != '0);
        end
    endgenerate
    wire [4*CW-1:0] granted;
    aslc_budget #(.CODE_W(CW)) u_budget (
        .req_codes   (cur.current_codes),
        .side_on     (side_on),
        .grant_codes (granted)
    );

    wire last_slot = (slot_reg == 4'(NUM_SLOTS - 1));
    wire [3:0] slot_inc = slot_reg + 4'h1;
    wire pre_done = (cnt_reg + 16'h0001 >= pre_len);
    wire pulse_done = (cnt_reg + 16'h0001 >= 16'(PULSE_CYC));

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ASLC_IDLE:  if (START_PERIOD) state_next = ASLC_NEXT;
            ASLC_NEXT:  if (SLOT_ENABLE[slot_reg]) state_next = ASLC_PRE;
                        else if (last_slot) state_next = ASLC_IDLE;
            ASLC_PRE:   if (pre_done) state_next = ASLC_PULSE;
            ASLC_PULSE: if (pulse_done) state_next = ASLC_CONV;
            ASLC_CONV:  if (ADC_DONE && (conv2_reg || !ch2_slot_reg))
                        state_next = last_slot ? ASLC_IDLE : ASLC_NEXT;
            default:    state_next = ASLC_IDLE;
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            state_reg    <= ASLC_IDLE;
            slot_reg     <= 4'h0;
            cnt_reg      <= 16'h0000;
            conv2_reg    <= 1'b0;
            codes_reg    <= '0;
            ch2_slot_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= (state_next != state_reg) ? 16'h0000 : cnt_reg + 16'h0001;
            if (state_reg == ASLC_IDLE)
                slot_reg <= 4'h0;
            else if ((state_reg == ASLC_NEXT && !SLOT_ENABLE[slot_reg]) ||
                     (state_reg == ASLC_CONV && state_next == ASLC_NEXT))
                slot_reg <= slot_inc;
            if (state_next == ASLC_PRE && state_reg != ASLC_PRE)
            begin
                codes_reg    <= granted;
                ch2_slot_reg <= ch2_allowed;
            end
            else if (state_next == ASLC_IDLE || state_next == ASLC_NEXT)
            begin
                codes_reg    <= '0;
                ch2_slot_reg <= 1'b0;
            end
            if (state_reg != ASLC_CONV)
                conv2_reg <= 1'b0;
            else if (ADC_DONE)
                conv2_reg <= 1'b1;
        end
    end

    wire in_pre   = (state_reg == ASLC_PRE);
    wire in_pulse = (state_reg == ASLC_PULSE);
    aslc_input_mux u_pair1 (
        .differential (FIRST_PAIR_DIFFERENTIAL),
        .route        (cur.first_pair_slot_route),
        .idle_state   (FIRST_PAIR_IDLE_STATE),
        .pre_state    (cur.slot_precondition_select),
        .in_pre       (in_pre && state_reg != ASLC_IDLE),
        .in_pulse     (in_pulse),
        .ch2_on       (ch2_slot_reg),
        .ctl_a        (IN_CTL[0]),
        .ctl_b        (IN_CTL[1])
    );
    aslc_input_mux u_pair2 (
        .differential (SECOND_PAIR_DIFFERENTIAL),
        .route        (cur.second_pair_slot_route),
        .idle_state   (SECOND_PAIR_IDLE_STATE),
        .pre_state    (cur.slot_precondition_select),
        .in_pre       (in_pre),
        .in_pulse     (in_pulse),
        .ch2_on       (ch2_slot_reg),
        .ctl_a        (IN_CTL[2]),
        .ctl_b        (IN_CTL[3])
    );

    // one converter, channel one first then channel two
    assign ADC_START   = (state_reg == ASLC_CONV) && !(ADC_DONE && conv2_reg);
    assign ADC_SEL_CH2 = (state_reg == ASLC_CONV) && conv2_reg;
    assign DATA_WRITE  = (state_reg == ASLC_CONV) && ADC_DONE;
    assign DATA_IS_CH2 = conv2_reg;
    assign CH2_POWER_ON = ch2_slot_reg;
    assign CH1_GAIN_APPLIED = CH1_GAIN;
    assign CH2_GAIN_APPLIED = ch2_slot_reg ? CH2_GAIN : '0;
    assign SLOT_ID  = slot_reg;
    assign BUSY     = (state_reg != ASLC_IDLE);
    // drivers sink only during the pulse region
    assign DRIVER_CODES = in_pulse ? codes_reg : '0;

    property p_ch2_off_no_conv;
        @(posedge MCLK) disable iff (RESET)
        !ch2_slot_reg |-> !ADC_SEL_CH2;
    endproperty
    a_ch2_off_no_conv: assert property (p_ch2_off_no_conv) else $error("ch2 converted while off");

    property p_budget;
        @(posedge MCLK) disable iff (RESET)
        in_pulse |-> (10'(DRIVER_CODES[0 +: CW]) + 10'(DRIVER_CODES[CW +: CW]) +
                      10'(DRIVER_CODES[2*CW +: CW]) + 10'(DRIVER_CODES[3*CW +: CW]))
                     <= 10'(`ASLC_BUDGET_CODES);
    endproperty
    a_budget: assert property (p_budget) else $error("driver total over budget");

    property p_pre_then_pulse;
        @(posedge MCLK) disable iff (RESET)
        $rose(in_pre) && (pre_len > 16'h0001) |-> in_pre [*2];
    endproperty
    a_pre_then_pulse: assert property (p_pre_then_pulse) else $error("precondition too short");

    property p_no_drive_outside_pulse;
        @(posedge MCLK) disable iff (RESET)
        !in_pulse |-> (DRIVER_CODES == '0);
    endproperty
    a_no_drive_outside_pulse: assert property (p_no_drive_outside_pulse) else $error("led on outside pulse");

    property p_ch2_after_ch1;
        @(posedge MCLK) disable iff (RESET)
        (DATA_WRITE && DATA_IS_CH2) |-> $past(conv2_reg) || $past(DATA_WRITE);
    endproperty
    a_ch2_after_ch1: assert property (p_ch2_after_ch1) else $error("ch2 data before ch1");

    property p_sampling_float;
        @(posedge MCLK) disable iff (RESET)
        (IN_CTL[0].to_ch1 || IN_CTL[0].to_ch2) |-> IN_CTL[0].state == aslc_pkg::ASLC_PC_FLOAT;
    endproperty
    a_sampling_float: assert property (p_sampling_float) else $error("bias closed while sampling");

    property p_idle_inputs;
        @(posedge MCLK) disable iff (RESET)
        !BUSY |-> (IN_CTL[2].state == SECOND_PAIR_IDLE_STATE);
    endproperty
    a_idle_inputs: assert property (p_idle_inputs) else $error("idle input not in idle state");

    property p_slot_range;
        @(posedge MCLK) disable iff (RESET)
        BUSY |-> slot_reg < 4'(NUM_SLOTS);
    endproperty
    a_slot_range: assert property (p_slot_range) else $error("slot index out of range");

    property p_ch2_off_idle;
        @(posedge MCLK) disable iff (RESET)
        !BUSY |-> !CH2_POWER_ON;
    endproperty
    a_ch2_off_idle: assert property (p_ch2_off_idle) else $error("ch2 powered while idle");

    property p_no_ch2_mode;
        @(posedge MCLK) disable iff (RESET)
        (in_pre || in_pulse) && SLOT_NO_CH2_MODE[slot_reg] |-> !CH2_POWER_ON;
    endproperty
    a_no_ch2_mode: assert property (p_no_ch2_mode) else $error("ch2 on in single-channel mode");

    property p_ch2_slot_gate;
        @(posedge MCLK) disable iff (RESET)
        (in_pre || in_pulse) && !cur.slot_second_channel_on |-> !CH2_POWER_ON;
    endproperty
    a_ch2_slot_gate: assert property (p_ch2_slot_gate) else $error("ch2 on in slot without it");

    property p_first_driver_full;
        @(posedge MCLK) disable iff (RESET)
        in_pulse && cur.side_select[0] |-> DRIVER_CODES[0 +: CW] == cur.current_codes[0 +: CW];
    endproperty
    a_first_driver_full: assert property (p_first_driver_full) else $error("first driver cut");

    property p_code_zero_off;
        @(posedge MCLK) disable iff (RESET)
        in_pulse && (cur.current_codes[CW +: CW] == '0) |-> DRIVER_CODES[CW +: CW] == '0;
    endproperty
    a_code_zero_off: assert property (p_code_zero_off) else $error("zero code driver on");

    property p_side_off_dark;
        @(posedge MCLK) disable iff (RESET)
        in_pulse && !cur.side_select[3] |-> DRIVER_CODES[3*CW +: CW] == '0;
    endproperty
    a_side_off_dark: assert property (p_side_off_dark) else $error("unselected driver on");

    property p_adc_in_conv;
        @(posedge MCLK) disable iff (RESET)
        ADC_START |-> (state_reg == ASLC_CONV);
    endproperty
    a_adc_in_conv: assert property (p_adc_in_conv) else $error("conversion outside convert");

    property p_ch2_write_powered;
        @(posedge MCLK) disable iff (RESET)
        (DATA_WRITE && DATA_IS_CH2) |-> CH2_POWER_ON;
    endproperty
    a_ch2_write_powered: assert property (p_ch2_write_powered) else $error("ch2 data while off");

    property p_outside_idle;
        @(posedge MCLK) disable iff (RESET)
        BUSY && !in_pre && !in_pulse |-> (IN_CTL[0].state == FIRST_PAIR_IDLE_STATE) &&
                                        (IN_CTL[1].state == FIRST_PAIR_IDLE_STATE);
    endproperty
    a_outside_idle: assert property (p_outside_idle) else $error("input active outside regions");

    property p_no_sample_in_pre;
        @(posedge MCLK) disable iff (RESET)
        in_pre |-> !(IN_CTL[1].to_ch1 || IN_CTL[1].to_ch2 || IN_CTL[3].to_ch1 || IN_CTL[3].to_ch2);
    endproperty
    a_no_sample_in_pre: assert property (p_no_sample_in_pre) else $error("sampling in precondition");

    property p_slot_step;
        @(posedge MCLK) disable iff (RESET)
        (state_reg == ASLC_CONV) && (state_next == ASLC_NEXT) |=> SLOT_ID == $past(slot_reg) + 4'h1;
    endproperty
    a_slot_step: assert property (p_slot_step) else $error("slot order broken");

    property p_ch2_gain_off;
        @(posedge MCLK) disable iff (RESET)
        !CH2_POWER_ON |-> CH2_GAIN_APPLIED == '0;
    endproperty
    a_ch2_gain_off: assert property (p_ch2_gain_off) else $error("ch2 gain applied while off");
endmodule // aslc_top

// >>> hw/aslc_consts.svh
// constants for the slot input / led control block
// assumes inclusion by the package, design and bench files
`ifndef ASLC_CONSTS_SVH
`define ASLC_CONSTS_SVH

`define ASLC_NUM_SLOTS      12
`define ASLC_NUM_DRIVERS    4
`define ASLC_CODE_W         7
`define ASLC_ADC_BITS       14
`define ASLC_CLK_MHZ        250
// precondition default in ns
`define ASLC_PRE_NS_DEF     8000
`define ASLC_PRE_CYC_DEF    ((`ASLC_PRE_NS_DEF * `ASLC_CLK_MHZ + 999) / 1000)
// total budget: 400 mA over ~1.6 mA per step = 250 code units
`define ASLC_BUDGET_UA      400000
`define ASLC_STEP_UA        1600
`define ASLC_BUDGET_CODES   (`ASLC_BUDGET_UA / `ASLC_STEP_UA)
// route field encodings
`define ASLC_RT_OFF         3'h0
`define ASLC_RT_A_CH1       3'h1
`define ASLC_RT_A_CH2       3'h2
`define ASLC_RT_B_CH1       3'h3
`define ASLC_RT_B_CH2       3'h4
`define ASLC_RT_A1_B2       3'h5
`define ASLC_RT_A2_B1       3'h6

`endif

// >>> hw/aslc_pkg.sv
// types for the slot input / led control block
// assumes aslc_consts.svh in the include path
`include "aslc_consts.svh"
package aslc_pkg;

    typedef enum logic [2:0] {
        ASLC_PC_FLOAT = 3'h0,
        ASLC_PC_BIAS1 = 3'h1,
        ASLC_PC_BIAS2 = 3'h2,
        ASLC_PC_ICM   = 3'h3,
        ASLC_PC_REF   = 3'h4,
        ASLC_PC_AMPIN = 3'h5,
        ASLC_PC_SHORT = 3'h6
    } aslc_pin_state_t;

    typedef struct packed {
        logic [2:0]       first_pair_slot_route;
        logic [2:0]       second_pair_slot_route;
        aslc_pin_state_t  slot_precondition_select;
        logic [15:0]      pre_cycles;
        logic             slot_second_channel_on;
        logic [3:0]       side_select;
        logic [27:0]      current_codes;
    } aslc_slot_cfg_t;

    // per input: state drive, channel connection
    typedef struct packed {
        aslc_pin_state_t  state;
        logic             to_ch1;
        logic             to_ch2;
    } aslc_input_ctl_t;

endpackage

// >>> hw/aslc_budget.sv
// priority current budget limiter over four drivers
// assumes codes are sampled once per slot by the caller
`include "aslc_consts.svh"
module aslc_budget #(
    parameter int CODE_W = `ASLC_CODE_W
) (
    input  wire logic [4*CODE_W-1:0] req_codes,
    input  wire logic [3:0]          side_on,
    output logic      [4*CODE_W-1:0] grant_codes
);
    localparam logic [9:0] BUDGET = 10'(`ASLC_BUDGET_CODES);
    logic [9:0] remain [0:4];
    assign remain[0] = BUDGET;
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_drv
            wire [9:0] want = side_on[i] ? 10'(req_codes[i*CODE_W +: CODE_W]) : 10'h000;
            wire [9:0] give = (want > remain[i]) ? remain[i] : want;
            assign grant_codes[i*CODE_W +: CODE_W] = CODE_W'(give);
            assign remain[i+1] = remain[i] - give;
        end
    endgenerate
endmodule // aslc_budget

// >>> hw/aslc_input_mux.sv
// one pair's input routing and idle/precondition state
// assumes phase flags from the slot sequencer
`include "aslc_consts.svh"
module aslc_input_mux (
    input  wire logic                     differential,
    input  wire logic [2:0]               route,
    input  wire aslc_pkg::aslc_pin_state_t idle_state,
    input  wire aslc_pkg::aslc_pin_state_t pre_state,
    input  wire logic                     in_pre,
    input  wire logic                     in_pulse,
    input  wire logic                     ch2_on,
    output aslc_pkg::aslc_input_ctl_t     ctl_a,
    output aslc_pkg::aslc_input_ctl_t     ctl_b
);
    wire en      = (route != `ASLC_RT_OFF);
    wire active  = en && (in_pre || in_pulse);
    wire a_c1 = (route == `ASLC_RT_A_CH1) || (route == `ASLC_RT_A1_B2);
    wire a_c2 = (route == `ASLC_RT_A_CH2) || (route == `ASLC_RT_A2_B1);
    wire b_c1 = (route == `ASLC_RT_B_CH1) || (route == `ASLC_RT_A2_B1);
    wire b_c2 = (route == `ASLC_RT_B_CH2) || (route == `ASLC_RT_A1_B2);
    // differential pair: both legs follow the routed one
    wire a_used = differential ? (a_c1 | a_c2 | b_c1 | b_c2) : (a_c1 | a_c2);
    wire b_used = differential ? a_used : (b_c1 | b_c2);
    wire d_c1 = a_c1 | b_c1;
    wire d_c2 = a_c2 | b_c2;
    // bias switches open while sampling
    aslc_pkg::aslc_pin_state_t st_a, st_b;
    assign st_a = !(active && a_used) ? idle_state :
                  in_pre ? pre_state : aslc_pkg::ASLC_PC_FLOAT;
    assign st_b = !(active && b_used) ? idle_state :
                  in_pre ? pre_state : aslc_pkg::ASLC_PC_FLOAT;
    wire samp = active && in_pulse;
    assign ctl_a = '{state: st_a,
                     to_ch1: samp && a_used && (differential ? d_c1 : a_c1),
                     to_ch2: samp && a_used && ch2_on && (differential ? d_c2 : a_c2)};
    assign ctl_b = '{state: st_b,
                     to_ch1: samp && b_used && (differential ? d_c1 : b_c1),
                     to_ch2: samp && b_used && ch2_on && (differential ? d_c2 : b_c2)};
endmodule // aslc_input_mux

// >>> sim/aslc_conv_model.sv
// converter stand-in: answers every conversion request with a one-cycle done
// assumes the sequencer holds its request high until done is seen
module aslc_conv_model (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic adc_start,
    input  wire logic slow,
    output logic      adc_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_reg;
    // slow answers catch a sequencer that drops its request early
    wire  [3:0] lat = slow ? 4'hB : 4'h1;
    always_ff @(posedge mclk)
    begin
        if (reset || !adc_start || adc_done)
        begin
            wait_reg <= 4'h0;
            adc_done <= 1'b0;
        end
        else
        begin
            wait_reg <= wait_reg + 4'h1;
            adc_done <= (wait_reg == lat);
        end
    end
endmodule // aslc_conv_model

// >>> sim/aslc_top_tb.sv
// self-checking bench for the slot sequencer, expectations queued by the driver
// assumes the converter stand-in and the design package are compiled first
`include "aslc_consts.svh"
`define CHK(nm, e, g) \
    begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp=%0h seen=%0h", nm, (e), (g)); end end
module aslc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PULSE = 16;
    typedef struct {
        logic [3:0]                slot;
        logic [27:0]               codes;
        int                        pre_len;
        logic                      a_on;
        aslc_pkg::aslc_pin_state_t smp_st;
        aslc_pkg::aslc_pin_state_t pre_st;
        aslc_pkg::aslc_pin_state_t p2a_st;
        logic                      ch2_on;
        logic                      p2b_ch2;
    } aslc_tb_pulse_t;
    logic                      mclk, reset, start_period, adc_done, slow, hung;
    logic                      ch2_pwr, adc_start, adc_sel2, data_write, data_ch2, busy;
    logic                      diff1, diff2;
    logic [11:0]               slot_enable, no_ch2;
    aslc_pkg::aslc_pin_state_t idle1, idle2;
    aslc_pkg::aslc_slot_cfg_t  slot_cfg [12];
    aslc_pkg::aslc_input_ctl_t in_ctl [4];
    logic [3:0]                ch1_gain, ch2_gain, ch1_app, ch2_app, slot_id;
    logic [27:0]               drv_codes, prev_codes;
    int                        bad_count, total_checks, pre_cnt, pulse_cnt, seed;
    aslc_tb_pulse_t            exp_q[$];
    aslc_tb_pulse_t            cur;
    logic [4:0]                wr_q[$];
    logic [4:0]                w;

    aslc_top #(.NUM_SLOTS(12), .PULSE_CYC(PULSE), .GAIN_W(4)) u_aslc_top (
        .MCLK(mclk), .RESET(reset), .START_PERIOD(start_period), .SLOT_ENABLE(slot_enable),
        .FIRST_PAIR_DIFFERENTIAL(diff1), .SECOND_PAIR_DIFFERENTIAL(diff2),
        .FIRST_PAIR_IDLE_STATE(idle1), .SECOND_PAIR_IDLE_STATE(idle2),
        .SLOT_NO_CH2_MODE(no_ch2), .SLOT_CFG(slot_cfg), .CH1_GAIN(ch1_gain),
        .CH2_GAIN(ch2_gain), .ADC_DONE(adc_done), .IN_CTL(in_ctl),
        .CH1_GAIN_APPLIED(ch1_app), .CH2_GAIN_APPLIED(ch2_app), .CH2_POWER_ON(ch2_pwr),
        .ADC_START(adc_start), .ADC_SEL_CH2(adc_sel2), .DATA_WRITE(data_write),
        .DATA_IS_CH2(data_ch2), .SLOT_ID(slot_id), .BUSY(busy), .DRIVER_CODES(drv_codes));
    aslc_conv_model u_aslc_conv_model (.mclk(mclk), .reset(reset), .adc_start(adc_start),
        .slow(slow), .adc_done(adc_done));

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    function automatic logic [27:0] grant(input logic [27:0] req, input logic [3:0] side);
        int          rem;
        int          g;
        logic [27:0] o;
        rem = `ASLC_BUDGET_CODES;
        o = '0;
        for (int i = 0; i < 4; i++)
        begin
            g = side[i] ? int'(req[i*7 +: 7]) : 0;
            if (g > rem)
                g = rem;
            rem -= g;
            o[i*7 +: 7] = g[6:0];
        end
        return o;
    endfunction

    always @(posedge mclk)
    begin
        if (!reset)
        begin
            if (data_write === 1'b1)
            begin
                `CHK("write pending", 1'b1, wr_q.size() > 0)
                if (wr_q.size() > 0)
                begin
                    w = wr_q.pop_front();
                    `CHK("write slot", w[4:1], slot_id)
                    `CHK("write channel", w[0], data_ch2)
                    `CHK("ch2 select", w[0], adc_sel2)
                    `CHK("ch1 gain", ch1_gain, ch1_app)
                    if (w[0])
                        `CHK("ch2 gain", ch2_gain, ch2_app)
                end
            end
            if (drv_codes !== '0 && prev_codes === '0)
            begin
                `CHK("pulse pending", 1'b1, exp_q.size() > 0)
                if (exp_q.size() > 0)
                begin
                    cur = exp_q.pop_front();
                    `CHK("pulse slot", cur.slot, slot_id)
                    `CHK("granted codes", cur.codes, drv_codes)
                    `CHK("input a state", cur.smp_st, in_ctl[0].state)
                    `CHK("input a ch1", cur.a_on, in_ctl[0].to_ch1)
                    `CHK("pair two a state", cur.p2a_st, in_ctl[2].state)
                    `CHK("pair two b ch2", cur.p2b_ch2, in_ctl[3].to_ch2)
                    `CHK("ch2 power", cur.ch2_on, ch2_pwr)
                    if (cur.pre_len != 0)
                        `CHK("pre length", cur.pre_len, pre_cnt)
                end
                pulse_cnt = 0;
            end
            if (drv_codes === '0 && prev_codes !== '0)
                `CHK("pulse length", PULSE, pulse_cnt)
            if (drv_codes !== '0)
                pulse_cnt++;
            // precondition cycles counted only while codes are dark
            if (exp_q.size() > 0 && busy === 1'b1 && drv_codes === '0
                && in_ctl[0].state === exp_q[0].pre_st)
                pre_cnt++;
            else
                pre_cnt = 0;
            prev_codes = drv_codes;
        end
    end

    task automatic run_period(input int per);
        aslc_pkg::aslc_slot_cfg_t c;
        aslc_tb_pulse_t           p;
        logic [2:0]               rt, rt2;
        int                       n;
        @(posedge mclk);
        slow <= per[0];
        diff1 <= per[0];
        diff2 <= !per[0];
        ch1_gain <= 4'($random(seed));
        ch2_gain <= 4'($random(seed));
        for (int s = 0; s < 12; s++)
        begin
            n = (s + per) % 4;
            rt = (n == 1) ? `ASLC_RT_A_CH1 : (n == 2) ? `ASLC_RT_B_CH1 :
                 (n == 3) ? `ASLC_RT_A1_B2 : `ASLC_RT_OFF;
            c.first_pair_slot_route = rt;
            rt2 = (n == 0) ? `ASLC_RT_B_CH2 : `ASLC_RT_OFF;
            c.second_pair_slot_route = rt2;
            c.slot_precondition_select = aslc_pkg::aslc_pin_state_t'(3'((s + per) % 7));
            c.pre_cycles = (s == 10 && per == 0) ? 16'h0 : 16'(3 + s);
            c.slot_second_channel_on = 1'($random(seed));
            c.side_select = 4'($random(seed)) | 4'h1;
            c.current_codes = 28'($random(seed)) | 28'h1;
            if (s == 2)
                c.current_codes[13:7] = 7'h00;
            if (s == 0)
            begin
                c.side_select = 4'hF;
                c.current_codes = 28'hFFFFFFF;
            end
            if (s == 1)
                c.current_codes = (c.current_codes & {4{7'h3C}}) | 28'h1;
            slot_cfg[s] <= c;
            slot_enable[s] <= (s != 5 || per == 1);
            no_ch2[s] <= (s == 3 || s == 8);
            if (s != 5 || per == 1)
            begin
                p.slot = 4'(s);
                p.codes = grant(c.current_codes, c.side_select);
                // differential pair: any enabled route uses both legs
                p.a_on = per[0] ? (rt != `ASLC_RT_OFF) :
                         ((rt == `ASLC_RT_A_CH1) || (rt == `ASLC_RT_A1_B2));
                p.ch2_on = c.slot_second_channel_on && !(s == 3 || s == 8);
                p.p2a_st = (!per[0] && rt2 != `ASLC_RT_OFF) ? aslc_pkg::ASLC_PC_FLOAT : idle2;
                p.p2b_ch2 = (rt2 != `ASLC_RT_OFF) && p.ch2_on;
                p.smp_st = p.a_on ? aslc_pkg::ASLC_PC_FLOAT : idle1;
                p.pre_st = c.slot_precondition_select;
                p.pre_len = (!p.a_on || p.pre_st == idle1) ? 0 :
                            (c.pre_cycles == 0) ? `ASLC_PRE_CYC_DEF : int'(c.pre_cycles);
                exp_q.push_back(p);
                wr_q.push_back({4'(s), 1'b0});
                if (p.ch2_on)
                    wr_q.push_back({4'(s), 1'b1});
            end
        end
        @(posedge mclk);
        start_period <= 1'b1;
        @(posedge mclk);
        start_period <= 1'b0;
        repeat (20) @(posedge mclk);
        // a second start inside the period must be ignored
        start_period <= 1'b1;
        @(posedge mclk);
        start_period <= 1'b0;
        for (n = 0; n < 20000 && busy !== 1'b0; n++)
            @(posedge mclk);
        `CHK("period done", 1'b0, busy)
        hung = (busy !== 1'b0);
        repeat (4) @(posedge mclk);
        `CHK("no restart", 1'b0, busy)
        `CHK("writes left", 0, wr_q.size())
        `CHK("pulses left", 0, exp_q.size())
    endtask

    task automatic close_out();
        $display("checks=%0d bad=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        seed = 32'hF090;
        reset = 1'b1;
        start_period = 1'b0;
        slow = 1'b0;
        hung = 1'b0;
        diff1 = 1'b0;
        diff2 = 1'b1;
        slot_enable = 12'h000;
        no_ch2 = 12'h000;
        idle1 = aslc_pkg::ASLC_PC_REF;
        idle2 = aslc_pkg::ASLC_PC_BIAS2;
        ch1_gain = 4'h0;
        ch2_gain = 4'h0;
        prev_codes = '0;
        for (int s = 0; s < 12; s++)
            slot_cfg[s] = '0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK("busy after reset", 1'b0, busy)
        `CHK("ch2 power after reset", 1'b0, ch2_pwr)
        `CHK("codes after reset", 28'h0, drv_codes)
        `CHK("idle input", idle1, in_ctl[0].state)
        for (int per = 0; per < 2 && !hung; per++)
            run_period(per);
        close_out();
    end
endmodule // aslc_top_tb
